// file: verilog/sdg_pkg.sv
// Behaviour
// - Overvoltage with guard on: 2 mA, no sleep.
// - Guard disabled: normal current and sleep entry.
// - Overvoltage flag set on entry, guard ignored.
// - Check bit 0: ignore wake falls, supply low.
// - Check bit 1: wake on any fall.
// - Style bit: 0 latch low, 1 pulse low.
// - Mux method: 0x serial, 10 two-bit, 11 three-bit.
// - Hardwired methods take channel from ground inputs.
// - Input bit 1 battery sensing, 0 ground.
// - Closed switch always reports as 1.
// - Poll bit: 1 ms at 0, 55 us at 1.
// - Reset: inputs battery, check 1, rest 0.
// - Response: fault, interrupt flag, then register data.
`default_nettype none
package sdg_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int          FRAME_W     = 32;
  localparam int          DATA_W      = 24;
  localparam int          ADDR_HI     = 31;
  localparam int          ADDR_LO     = 25;
  localparam int          RW_BIT      = 24;
  localparam int          RESP_DATA_W = 22;
  localparam logic [6:0]  ADDR_CFG    = 7'h01;

  // ****************************************************************
  // Configuration register fields and reset value
  // ****************************************************************
  localparam int          CFG_POLL    = 13;
  localparam int          CFG_OV_DIS  = 12;
  localparam int          CFG_WCHK    = 11;
  localparam int          CFG_ISTYLE  = 10;
  localparam int          CFG_AM_HI   = 9;
  localparam int          CFG_AM_LO   = 8;
  localparam int          NUM_PROG    = 8;
  localparam logic [23:0] CFG_RST     = 24'h0008ff;
  localparam logic [23:0] CFG_WMASK   = 24'h003fff;
  localparam logic [1:0]  AM_HW2      = 2'h2;
  localparam logic [1:0]  AM_HW3      = 2'h3;

  // ****************************************************************
  // Synchronised input vector layout
  // ****************************************************************
  localparam int          IN_OV       = 0;
  localparam int          IN_SUP      = 1;
  localparam int          IN_WAKE     = 2;
  localparam int          IN_TOG      = 3;
  localparam int          IN_SG       = 4;
  localparam int          IN_PROG     = 7;
  localparam int          IN_W        = 15;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_MHZ        = 200;
  localparam int          POLL_SLOW_US   = 1000;
  localparam int          POLL_FAST_US   = 55;
  localparam int          INT_PULSE_NS   = 1000;
  localparam int          POLL_SLOW_CYC  = POLL_SLOW_US * CLK_MHZ;
  localparam int          POLL_FAST_CYC  = POLL_FAST_US * CLK_MHZ;
  localparam int          INT_PULSE_CYC  = (INT_PULSE_NS * CLK_MHZ) / 1000;
  localparam int          POLL_CW        = 18;
  localparam int          PULSE_CW       = 8;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b01,
    ST_SLEEP  = 2'b10
  } sdg_state_t;

endpackage
`default_nettype wire

// file: verilog/sdg_global_config.sv
`timescale 1ns/1ps
`default_nettype none
module sdg_global_config
  import sdg_pkg::*;
#(
  parameter int POLL_SLOW = POLL_SLOW_CYC,
  parameter int POLL_FAST = POLL_FAST_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                mosi,
  output logic                     miso,
  output logic                     miso_oe,
  input  wire logic                battery_overvoltage,
  input  wire logic                logic_supply_rail,
  input  wire logic                wake_n,
  input  wire logic [3:1]          ground_switch_input,
  input  wire logic [7:0]          programmable_switch_input,
  input  wire logic                fault_summary,
  input  wire logic                interrupt_flag,
  input  wire logic                interrupt_event,
  input  wire logic                interrupt_clear,
  input  wire logic                ov_flag_clear,
  input  wire logic                sleep_request,
  input  wire logic                wake_request,
  input  wire logic [5:0]          analog_selector_output_serial_channel,
  output logic                     wetting_limit_2ma,
  output logic                     excess_battery_voltage_flag,
  output logic                     in_sleep_state,
  output logic                     wake_pulse,
  output logic                     interrupt_n,
  output logic [5:0]               analog_selector_channel,
  output logic                     analog_selector_hardwired,
  output logic [7:0]               battery_sensing,
  output logic [7:0]               switch_closed,
  output logic                     poll_tick
);

  // ****************************************************************
  // Link domain state
  // ****************************************************************
  typedef struct packed {
    logic [4:0]          cnt;
    logic [FRAME_W-1:0]  rx;
    logic [FRAME_W-1:0]  tx;
  } sdg_link_t;

  typedef struct packed {
    logic [FRAME_W-1:0]  word;
    logic                tog;
  } sdg_hold_t;

  // ****************************************************************
  // Core domain state
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:0]   cfg;
    logic [FRAME_W-1:0]  resp;
    logic [IN_W-1:0]     s1;
    logic [IN_W-1:0]     s2;
    logic [IN_W-1:0]     s3;
    logic [IN_W-1:0]     filt;
    logic                ov_flag;
    logic                clamp;
    sdg_state_t          state;
    logic                wake_p;
    logic                int_low;
    logic [PULSE_CW-1:0] int_cnt;
    logic                int_n;
    logic [POLL_CW-1:0]  poll_cnt;
    logic                poll_p;
    logic [7:0]          closed;
    logic [5:0]          analog_selector_output;
    logic                analog_selector_output_hw;
  } sdg_core_t;

  sdg_link_t           lnk_q;
  sdg_link_t           lnk_d;
  sdg_hold_t           hold_q;
  sdg_hold_t           hold_d;
  sdg_core_t           core_q;
  sdg_core_t           core_d;
  logic                lnk_rst;
  logic                lnk_last;
  logic [IN_W-1:0]     in_raw;
  logic [IN_W-1:0]     agree;
  logic                frame_ev;
  logic [6:0]          rx_addr;
  logic                rx_write;
  logic                ov_rise;
  logic                wake_fall;
  logic [2:0]          sg_lvl;
  logic [POLL_CW-1:0]  poll_reload;

  // ****************************************************************
  // Serial shifter on the link clock
  // ****************************************************************
  // The shifter is cleared by chip select itself, because the link clock
  // stops between frames and cannot be relied on to end a frame.
  assign lnk_rst  = rst | cs_n;
  assign lnk_last = (lnk_q.cnt == 5'(FRAME_W - 1));

  always_comb begin
    lnk_d     = lnk_q;
    lnk_d.cnt = lnk_q.cnt + 5'h01;
    lnk_d.rx  = {lnk_q.rx[FRAME_W-2:0], mosi};
    if (lnk_q.cnt == 5'h00) begin
      lnk_d.tx = {core_q.resp[FRAME_W-2:0], 1'b0};
    end else begin
      lnk_d.tx = {lnk_q.tx[FRAME_W-2:0], 1'b0};
    end
    hold_d = hold_q;
    if (lnk_last) begin
      hold_d.word = {lnk_q.rx[FRAME_W-2:0], mosi};
      hold_d.tog  = ~hold_q.tog;
    end
  end

  always_ff @(posedge sclk or posedge lnk_rst) begin
    if (lnk_rst) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // The received word only changes at the end of the next full frame, so
  // it stays steady long after the toggle has crossed.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // The first response bit is shown straight from the core register; the
  // host must leave chip select high long enough for it to settle.
  assign miso    = (lnk_q.cnt == 5'h00) ? core_q.resp[FRAME_W-1]
                                        : lnk_q.tx[FRAME_W-1];
  assign miso_oe = ~cs_n;

  // ****************************************************************
  // Core logic
  // ****************************************************************
  assign in_raw = {programmable_switch_input, ground_switch_input,
                   hold_q.tog, wake_n, logic_supply_rail,
                   battery_overvoltage};
  assign agree  = ~(core_q.s2 ^ core_q.s3);

  assign frame_ev  = agree[IN_TOG] & (core_q.s3[IN_TOG] ^ core_q.filt[IN_TOG]);
  assign rx_addr   = hold_q.word[ADDR_HI:ADDR_LO];
  assign rx_write  = hold_q.word[RW_BIT];
  assign ov_rise   = agree[IN_OV] & core_q.s3[IN_OV] & ~core_q.filt[IN_OV];
  assign wake_fall = agree[IN_WAKE] & ~core_q.s3[IN_WAKE]
                   & core_q.filt[IN_WAKE];
  assign sg_lvl    = core_q.filt[IN_SG +: 3];
  assign poll_reload = core_q.cfg[CFG_POLL]
                     ? POLL_CW'(POLL_FAST - 1)
                     : POLL_CW'(POLL_SLOW - 1);

  always_comb begin
    core_d        = core_q;
    core_d.s1     = in_raw;
    core_d.s2     = core_q.s1;
    core_d.s3     = core_q.s2;
    core_d.filt   = (agree & core_q.s3) | (~agree & core_q.filt);
    core_d.wake_p = 1'b0;
    core_d.poll_p = 1'b0;

    // Register access, one word per completed frame.
    if (frame_ev) begin
      if (rx_write && (rx_addr == ADDR_CFG)) begin
        core_d.cfg = hold_q.word[DATA_W-1:0] & CFG_WMASK;
      end
      core_d.resp = {hold_q.word[FRAME_W-1:DATA_W], fault_summary,
                     interrupt_flag, RESP_DATA_W'(0)};
      if (rx_addr == ADDR_CFG) begin
        core_d.resp[RESP_DATA_W-1:0] =
          core_d.cfg[RESP_DATA_W-1:0];
      end
    end

    // Overvoltage guard and sticky flag; a new entry beats a clear.
    core_d.clamp = core_q.filt[IN_OV]
                 & ~core_q.cfg[CFG_OV_DIS];
    core_d.ov_flag = (core_q.ov_flag & ~ov_flag_clear) | ov_rise;

    // Sleep entry and wake.
    case (core_q.state)
      ST_NORMAL: begin
        if (sleep_request && !core_q.clamp) begin
          core_d.state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_request ||
            (wake_fall &&
             (core_q.cfg[CFG_WCHK] ||
              core_q.filt[IN_SUP]))) begin
          core_d.state  = ST_NORMAL;
          core_d.wake_p = 1'b1;
        end
      end
      default: begin
        core_d.state = ST_NORMAL;
      end
    endcase

    // Interrupt pin: latched until cleared, or a fixed low pulse.
    if (core_q.int_cnt != '0) begin
      core_d.int_cnt = core_q.int_cnt - PULSE_CW'(1);
    end
    if (interrupt_clear) begin
      core_d.int_low = 1'b0;
    end
    if (interrupt_event) begin
      if (core_q.cfg[CFG_ISTYLE]) begin
        core_d.int_cnt = PULSE_CW'(INT_PULSE_CYC);
      end else begin
        core_d.int_low = 1'b1;
      end
    end
    core_d.int_n = ~(core_d.int_low | (core_d.int_cnt != '0));

    // Poll timer for battery-sensed inputs.
    if (core_q.poll_cnt == '0) begin
      core_d.poll_cnt = poll_reload;
      core_d.poll_p   = 1'b1;
    end else begin
      core_d.poll_cnt = core_q.poll_cnt - POLL_CW'(1);
    end

    // A closed switch reads as one in either sensing polarity.
    core_d.closed = ~(core_q.filt[IN_PROG +: NUM_PROG]
                    ^ core_q.cfg[NUM_PROG-1:0]);

    // Analog selector source.
    case (core_q.cfg[CFG_AM_HI:CFG_AM_LO])
      AM_HW2: begin
        core_d.analog_selector_output    = {4'h0, sg_lvl[1:0]};
        core_d.analog_selector_output_hw = 1'b1;
      end
      AM_HW3: begin
        core_d.analog_selector_output    = {3'h0, sg_lvl};
        core_d.analog_selector_output_hw = 1'b1;
      end
      default: begin
        core_d.analog_selector_output    = analog_selector_output_serial_channel;
        core_d.analog_selector_output_hw = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_q         <= '0;
      core_q.cfg     <= CFG_RST;
      core_q.state   <= ST_NORMAL;
      core_q.int_n   <= 1'b1;
      core_q.analog_selector_output_hw <= 1'b0;
    end else begin
      core_q <= core_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wetting_limit_2ma           = core_q.clamp;
  assign excess_battery_voltage_flag = core_q.ov_flag;
  assign in_sleep_state              = (core_q.state == ST_SLEEP);
  assign wake_pulse                  = core_q.wake_p;
  assign interrupt_n                 = core_q.int_n;
  assign analog_selector_channel     = core_q.analog_selector_output;
  assign analog_selector_hardwired   = core_q.analog_selector_output_hw;
  assign battery_sensing             = core_q.cfg[NUM_PROG-1:0];
  assign switch_closed               = core_q.closed;
  assign poll_tick                   = core_q.poll_p;

endmodule
`default_nettype wire

// file: bench/sdg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sdg_checker
  import sdg_pkg::*;
#(
  parameter int POLL_SLOW = POLL_SLOW_CYC,
  parameter int POLL_FAST = POLL_FAST_CYC
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       miso_oe,
  input wire logic       battery_overvoltage,
  input wire logic       interrupt_event,
  input wire logic       interrupt_n,
  input wire logic       in_sleep_state,
  input wire logic       wake_pulse,
  input wire logic       wetting_limit_2ma,
  input wire logic       excess_battery_voltage_flag,
  input wire logic       analog_selector_hardwired,
  input wire logic [5:0] analog_selector_channel,
  input wire logic [7:0] programmable_switch_input,
  input wire logic [7:0] battery_sensing,
  input wire logic [7:0] switch_closed,
  input wire logic       poll_tick
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Six quiet cycles cover the three-stage input sync plus the register.
  sequence prog_steady;
    ($stable(programmable_switch_input) && $stable(battery_sensing))[*6];
  endsequence

  // Cycles since the last poll tick; the first tick after reset has no gap.
  int   poll_gap_q;
  logic poll_seen_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      poll_gap_q  <= 0;
      poll_seen_q <= 1'b0;
    end else if (poll_tick) begin
      poll_gap_q  <= 1;
      poll_seen_q <= 1'b1;
    end else begin
      poll_gap_q  <= poll_gap_q + 1;
    end
  end

  AST_OV_FLAG: assert property (
    $rose(battery_overvoltage) |-> ##[1:6] excess_battery_voltage_flag)
    else $error("overvoltage flag not set");
  AST_SLEEP_CLAMP: assert property (
    $rose(in_sleep_state) |-> !$past(wetting_limit_2ma))
    else $error("sleep entered while clamped");
  AST_INT_EDGE: assert property (
    interrupt_event |=> !interrupt_n)
    else $error("interrupt pin not driven low");
  AST_INT_CAUSE: assert property (
    $fell(interrupt_n) |-> $past(interrupt_event))
    else $error("interrupt pin fell without event");
  AST_WAKE: assert property (
    wake_pulse |-> !in_sleep_state && $past(in_sleep_state))
    else $error("wake pulse without leaving sleep");
  AST_MISO_OE: assert property (
    miso_oe == !cs_n)
    else $error("miso enable does not follow frame select");
  AST_HW_CH: assert property (
    analog_selector_hardwired |-> analog_selector_channel[5:3] == 3'h0)
    else $error("hardwired channel out of range");
  AST_SWITCH: assert property (
    prog_steady |-> switch_closed ==
      ~(programmable_switch_input ^ battery_sensing))
    else $error("switch status wrong");
  AST_POLL: assert property (
    poll_tick |=> (!poll_tick)[*8])
    else $error("poll ticks too close");
  AST_POLL_GAP: assert property (
    poll_tick && poll_seen_q |->
      (poll_gap_q == POLL_FAST) || (poll_gap_q == POLL_SLOW))
    else $error("poll period is neither poll setting");
endmodule
bind sdg_global_config sdg_checker #(
  .POLL_SLOW(POLL_SLOW),
  .POLL_FAST(POLL_FAST)
) u_chk (.*);
`default_nettype wire

// file: bench/sdg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdg_host_model
  import sdg_pkg::*;
(
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // ****************************************************************
  // Serial master
  // ****************************************************************
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // The clock stands low between frames; idle data is inverted on purpose.
  task automatic frame(input logic [31:0] w, output logic [31:0] r);
    cs_n = 1'b0;
    for (int i = FRAME_W - 1; i >= 0; i--) begin
      mosi = w[i];
      #80;
      r[i] = miso;
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
    end
    #80;
    cs_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_sdg_global_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sdg_global_config
  import sdg_pkg::*;
;
  logic clk, rst, sclk, cs_n, mosi, miso, miso_oe, poll_tick;
  logic battery_overvoltage, logic_supply_rail, wake_n, fault_summary;
  logic interrupt_flag, interrupt_event, interrupt_clear, ov_flag_clear;
  logic sleep_request, wake_request, wetting_limit_2ma, in_sleep_state;
  logic excess_battery_voltage_flag, wake_pulse, interrupt_n;
  logic analog_selector_hardwired;
  logic [3:1]  ground_switch_input;
  logic [5:0]  analog_selector_output_serial_channel, analog_selector_channel;
  logic [7:0]  programmable_switch_input, battery_sensing, switch_closed;
  logic [31:0] rsp;
  logic        pulse_seen;
  logic [31:0] exp_ch [4] = '{32'h2a, 32'h2a, 32'h01, 32'h05};
  int          error_cnt = 0;
  int          checked = 0;

  localparam int T_SLOW = 40;
  localparam int T_FAST = 10;

  sdg_global_config #(.POLL_SLOW(T_SLOW), .POLL_FAST(T_FAST)) dut (.*);
  sdg_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Measures the cycles between two poll ticks, each wait bounded.
  task automatic poll_gap(input int exp);
    int n;
    n = 0;
    while (poll_tick !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    n = 0;
    tick(1);
    while (poll_tick !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("poll gap", 32'(n + 1), 32'(exp));
  endtask
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    host.frame({a, 1'b1, d}, rsp);
    tick(20);
  endtask
  // The reply to a frame only arrives during the following frame.
  task automatic rd(input logic [21:0] exp);
    host.frame({ADDR_CFG, 1'b0, 24'h0}, rsp);
    host.frame({ADDR_CFG, 1'b0, 24'h0}, rsp);
    chk("cfg reply", rsp, {ADDR_CFG, 1'b0, 1'b1, 1'b0, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    {battery_overvoltage, logic_supply_rail, interrupt_event} = 3'h0;
    {interrupt_clear, ov_flag_clear, sleep_request} = 3'h0;
    {wake_request, interrupt_flag} = 2'h0;
    fault_summary = 1'b1;
    wake_n = 1'b1;
    ground_switch_input = 3'h5;
    programmable_switch_input = 8'h3c;
    analog_selector_output_serial_channel = 6'h2a;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    tick(5);
    chk("battery_sensing", 32'(battery_sensing), 32'hff);
    rd(22'h0008ff);
    chk("miso_oe", 32'(miso_oe), 32'h0);
    $display("reset test done");
    wr(ADDR_CFG, 24'hffe3a5);
    wr(7'h02, 24'h000000);
    rd(22'h0023a5);
    chk("battery_sensing", 32'(battery_sensing), 32'ha5);
    chk("switch_closed", 32'(switch_closed), 32'h66);
    poll_gap(T_FAST);
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CFG, {14'h0, 2'(m), 8'h5a});
      tick(4);
      chk("hardwired", 32'(analog_selector_hardwired),
          32'(m >= 2));
      chk("channel", 32'(analog_selector_channel), exp_ch[m]);
      chk("switch_closed", 32'(switch_closed), 32'h99);
    end
    poll_gap(T_SLOW);
    $display("selector test done");
    battery_overvoltage = 1'b1;
    tick(10);
    chk("ov flag", 32'(excess_battery_voltage_flag), 32'h1);
    chk("clamp", 32'(wetting_limit_2ma), 32'h1);
    sleep_request = 1'b1;
    tick(1);
    sleep_request = 1'b0;
    tick(2);
    chk("sleep", 32'(in_sleep_state), 32'h0);
    wr(ADDR_CFG, 24'h00135a);
    chk("clamp", 32'(wetting_limit_2ma), 32'h0);
    chk("ov flag", 32'(excess_battery_voltage_flag), 32'h1);
    sleep_request = 1'b1;
    tick(1);
    sleep_request = 1'b0;
    tick(2);
    chk("sleep", 32'(in_sleep_state), 32'h1);
    wake_n = 1'b0;
    tick(10);
    chk("sleep", 32'(in_sleep_state), 32'h1);
    wake_n = 1'b1;
    wr(ADDR_CFG, 24'h001b5a);
    wake_n = 1'b0;
    pulse_seen = 1'b0;
    repeat (10) begin
      tick(1);
      pulse_seen = pulse_seen | wake_pulse;
    end
    chk("sleep", 32'(in_sleep_state), 32'h0);
    chk("wake pulse", 32'(pulse_seen), 32'h1);
    battery_overvoltage = 1'b0;
    ov_flag_clear = 1'b1;
    tick(1);
    ov_flag_clear = 1'b0;
    tick(2);
    chk("ov flag", 32'(excess_battery_voltage_flag), 32'h0);
    $display("supply test done");
    interrupt_event = 1'b1;
    tick(1);
    interrupt_event = 1'b0;
    tick(250);
    chk("int latched", 32'(interrupt_n), 32'h0);
    interrupt_clear = 1'b1;
    tick(1);
    interrupt_clear = 1'b0;
    tick(2);
    chk("int released", 32'(interrupt_n), 32'h1);
    wr(ADDR_CFG, 24'h001f5a);
    interrupt_event = 1'b1;
    tick(1);
    interrupt_event = 1'b0;
    tick(100);
    chk("int pulse", 32'(interrupt_n), 32'h0);
    tick(150);
    chk("int pulse end", 32'(interrupt_n), 32'h1);
    $display("interrupt test done");
    end_of_test();
  end
endmodule
`default_nettype wire
